// File: rtl/cruise_control.sv
// cruise control state machine with apb status and control registers
// How it works
// - set latches speed within window, engages
// - main lamp follows switch, engaged lamp holding
// - held resume raises set speed to max
// - held set button lowers set speed
// - cancel, pedal, gear, traction drop holding
// - more than two buttons while holding clears set speed
// - speed 13 below set cancels holding
// - hot coolant cancels, main lamp blinks slowly
// - diagnosis fault cancels, engaged lamp blinks fast
// - any malfunction stops throttle command
// - main switch off erases set speed
// - resume after cancel returns to set speed
// - resume gated by pedals, selector, speed window
// - speed held by throttle angle command only
// - brake from two switches, clutch switch
module cruise_control
  import cruise_pkg::*;
#(
  parameter int RAMP_CYCLES = RAMP_CYC,
  parameter int SLOW_CYCLES = SLOW_BLINK_CYC,
  parameter int FAST_CYCLES = FAST_BLINK_CYC
) (
  input wire logic mclk, // system clock 20 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire pins_t pins, // raw driver and vehicle pins
  input wire net_msg_t net_msg, // network speed and revolution
  input wire logic net_valid, // one-cycle strobe for net_msg
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error for unmapped address
  output logic main_lamp, // main-on indicator
  output logic engaged_lamp, // engaged indicator
  output logic [7:0] throttle_cmd, // throttle angle command
  output logic throttle_active // throttle under cruise command
);
  localparam int NPINS = $bits(pins_t);
  pins_t sp;
  cruise_state_t state_reg;
  cruise_state_t state_next;
  logic [SPEED_W-1:0] speed_reg;
  logic [SPEED_W-1:0] powertrain_reg;
  logic [SPEED_W-1:0] set_speed_reg;
  logic set_valid_reg;
  logic [1:0] ctrl_reg;
  logic [31:0] ramp_cnt_reg;
  logic ramp_tick;
  logic [31:0] slow_cnt_reg;
  logic [31:0] fast_cnt_reg;
  logic slow_ph_reg;
  logic fast_ph_reg;
  logic set_d_reg;
  logic resume_d_reg;
  logic set_rise;
  logic resume_rise;
  logic brake;
  logic manual;
  logic gear_cancel;
  logic multi_press;
  logic speed_drop;
  logic fault;
  logic cancel_cond;
  logic in_window;
  logic resume_ok;
  logic holding;
  logic [1:0] press_cnt;

  pin_sync #(.WIDTH(NPINS)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_in(pins),
    .pin_out(sp)
  );

  // network words captured on their strobe; same clock, no sync
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      speed_reg <= '0;
      powertrain_reg <= '0;
    end else if (net_valid) begin
      speed_reg <= net_msg.vehicle_speed;
      powertrain_reg <= net_msg.powertrain_rev;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      set_d_reg <= 1'b0;
      resume_d_reg <= 1'b0;
    end else begin
      set_d_reg <= sp.set_btn;
      resume_d_reg <= sp.resume_btn;
    end
  end
  assign set_rise = sp.set_btn && !set_d_reg;
  assign resume_rise = sp.resume_btn && !resume_d_reg;

  assign manual = ctrl_reg[CTRL_MANUAL_BIT];
  assign brake = sp.brake_sw || sp.stop_lamp_sw;
  // only the neutral switch is shared by both gearbox kinds
  assign gear_cancel = manual ? (sp.neutral_sw || sp.clutch_sw)
                              : (sp.neutral_sw || sp.park_sw
                                 || sp.reverse_sw);
  assign press_cnt = 2'(sp.set_btn) + 2'(sp.resume_btn)
                     + 2'(sp.cancel_btn);
  // three buttons only: more than two means all pressed
  assign multi_press = press_cnt > 2'h2;
  // nine bits, so a high speed cannot wrap the sum into a false drop
  assign speed_drop = {1'b0, speed_reg} + SPEED_DROP_KMH
                      <= set_speed_reg;
  assign fault = sp.diag_fault || sp.coolant_hot;
  assign cancel_cond = sp.cancel_btn || brake || gear_cancel
                       || sp.traction_control || speed_drop
                       || fault || multi_press;
  assign in_window = speed_reg >= SPEED_MIN_KMH
                     && speed_reg <= SPEED_MAX_KMH;
  assign resume_ok = set_valid_reg && !brake
                     && !(manual && sp.clutch_sw)
                     && !(!manual && (sp.park_sw || sp.neutral_sw))
                     && speed_reg > SPEED_MIN_KMH
                     && speed_reg < SPEED_MAX_KMH
                     && !fault;
  assign holding = state_reg == ST_ENGAGED || state_reg == ST_ACCEL
                   || state_reg == ST_COAST;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (sp.main_sw && ctrl_reg[CTRL_ENABLE_BIT]) begin
          state_next = ST_STANDBY;
        end
      end
      ST_STANDBY, ST_CANCELLED: begin
        if (set_rise && in_window && !fault && !cancel_cond) begin
          state_next = ST_ENGAGED;
        end else if (resume_rise && resume_ok) begin
          state_next = ST_ENGAGED;
        end
      end
      ST_ENGAGED: begin
        if (cancel_cond) begin
          state_next = ST_CANCELLED;
        end else if (sp.resume_btn && !resume_d_reg) begin
          state_next = ST_ACCEL;
        end else if (sp.set_btn && !set_d_reg) begin
          state_next = ST_COAST;
        end
      end
      ST_ACCEL: begin
        if (cancel_cond) begin
          state_next = ST_CANCELLED;
        end else if (!sp.resume_btn) begin
          state_next = ST_ENGAGED;
        end
      end
      ST_COAST: begin
        if (cancel_cond) begin
          state_next = ST_CANCELLED;
        end else if (!sp.set_btn) begin
          state_next = ST_ENGAGED;
        end
      end
      default: state_next = ST_OFF;
    endcase
    if (!sp.main_sw || !ctrl_reg[CTRL_ENABLE_BIT]) begin
      state_next = ST_OFF;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ramp_cnt_reg <= '0;
    end else if (state_reg == ST_ACCEL || state_reg == ST_COAST) begin
      if (ramp_tick) begin
        ramp_cnt_reg <= '0;
      end else begin
        ramp_cnt_reg <= ramp_cnt_reg + 32'h1;
      end
    end else begin
      ramp_cnt_reg <= '0;
    end
  end
  assign ramp_tick = ramp_cnt_reg == 32'(RAMP_CYCLES - 1);

  // set speed memory; main-off, and multi-press while holding, erase it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      set_speed_reg <= '0;
      set_valid_reg <= 1'b0;
    end else if (state_next == ST_OFF) begin
      set_speed_reg <= '0;
      set_valid_reg <= 1'b0;
    end else if (holding && multi_press) begin
      set_speed_reg <= '0;
      set_valid_reg <= 1'b0;
    end else if ((state_reg == ST_STANDBY || state_reg == ST_CANCELLED)
                 && state_next == ST_ENGAGED && set_rise) begin
      set_speed_reg <= speed_reg;
      set_valid_reg <= 1'b1;
    end else if (state_reg == ST_ACCEL && ramp_tick
                 && set_speed_reg < SPEED_MAX_KMH) begin
      set_speed_reg <= set_speed_reg + 8'h1;
    end else if (state_reg == ST_COAST && ramp_tick
                 && set_speed_reg > SPEED_MIN_KMH) begin
      set_speed_reg <= set_speed_reg - 8'h1;
    end
  end

  // stepwise angle trim; servo loop lives downstream
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      throttle_cmd <= THROTTLE_IDLE;
      throttle_active <= 1'b0;
    end else if (!holding || fault || state_next == ST_OFF
                 || state_next == ST_CANCELLED) begin
      throttle_cmd <= THROTTLE_IDLE;
      throttle_active <= 1'b0;
    end else if (net_valid) begin
      throttle_active <= 1'b1;
      if (speed_reg < set_speed_reg && throttle_cmd < THROTTLE_MAX) begin
        throttle_cmd <= throttle_cmd + THROTTLE_STEP;
      end else if (speed_reg > set_speed_reg
                   && throttle_cmd > THROTTLE_IDLE) begin
        throttle_cmd <= throttle_cmd - THROTTLE_STEP;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      slow_cnt_reg <= '0;
      slow_ph_reg <= 1'b0;
      fast_cnt_reg <= '0;
      fast_ph_reg <= 1'b0;
    end else begin
      if (slow_cnt_reg == 32'(SLOW_CYCLES - 1)) begin
        slow_cnt_reg <= '0;
        slow_ph_reg <= !slow_ph_reg;
      end else begin
        slow_cnt_reg <= slow_cnt_reg + 32'h1;
      end
      if (fast_cnt_reg == 32'(FAST_CYCLES - 1)) begin
        fast_cnt_reg <= '0;
        fast_ph_reg <= !fast_ph_reg;
      end else begin
        fast_cnt_reg <= fast_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      main_lamp <= 1'b0;
      engaged_lamp <= 1'b0;
    end else begin
      if (state_next == ST_OFF) begin
        main_lamp <= 1'b0;
      end else if (sp.coolant_hot) begin
        main_lamp <= slow_ph_reg;
      end else begin
        main_lamp <= 1'b1;
      end
      if (state_next != ST_OFF && sp.diag_fault) begin
        engaged_lamp <= fast_ph_reg;
      end else begin
        engaged_lamp <= state_next == ST_ENGAGED
                        || state_next == ST_ACCEL
                        || state_next == ST_COAST;
      end
    end
  end

  // apb slave: zero wait states, unmapped reads zero with error
  logic apb_access;
  logic mapped;
  assign apb_access = psel && penable;
  assign mapped = paddr == OFF_CTRL || paddr == OFF_STATUS
                  || paddr == OFF_SET_SPEED || paddr == OFF_THROTTLE;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (apb_access && pwrite && paddr == OFF_CTRL) begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          OFF_CTRL: prdata <= {30'h0, ctrl_reg};
          OFF_STATUS: prdata <= {16'h0, powertrain_reg, 1'b0,
                                 sp.coolant_hot, sp.diag_fault,
                                 set_valid_reg, 1'b0, state_reg};
          OFF_SET_SPEED: prdata <= {16'h0, speed_reg, set_speed_reg};
          OFF_THROTTLE: prdata <= {23'h0, throttle_active, throttle_cmd};
          default: prdata <= '0;
        endcase
      end
    end
  end
endmodule : cruise_control

// File: rtl/cruise_pkg.sv
// constants and carrier types for the cruise control block
package cruise_pkg;
  localparam int SPEED_W = 8;
  localparam logic [7:0] SPEED_MIN_KMH = 8'h28;
  localparam logic [7:0] SPEED_MAX_KMH = 8'h90;
  localparam logic [7:0] SPEED_DROP_KMH = 8'h0d;
  localparam int CLK_HZ = 20000000;
  localparam int RAMP_MS = 100;
  localparam int RAMP_CYC = CLK_HZ / 1000 * RAMP_MS;
  localparam int SLOW_BLINK_MS = 500;
  localparam int SLOW_BLINK_CYC = CLK_HZ / 1000 * SLOW_BLINK_MS;
  localparam int FAST_BLINK_MS = 125;
  localparam int FAST_BLINK_CYC = CLK_HZ / 1000 * FAST_BLINK_MS;
  localparam logic [7:0] THROTTLE_IDLE = 8'h00;
  localparam logic [7:0] THROTTLE_STEP = 8'h01;
  localparam logic [7:0] THROTTLE_MAX = 8'hff;
  localparam int SYNC_STAGES = 3;
  localparam logic [31:0] OFF_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFF_STATUS = 32'h0000_0004;
  localparam logic [31:0] OFF_SET_SPEED = 32'h0000_0008;
  localparam logic [31:0] OFF_THROTTLE = 32'h0000_000c;
  localparam int CTRL_MANUAL_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF, ST_STANDBY, ST_ENGAGED, ST_ACCEL, ST_COAST, ST_CANCELLED
  } cruise_state_t;

  typedef struct packed {
    logic main_sw;
    logic set_btn;
    logic resume_btn;
    logic cancel_btn;
    logic brake_sw;
    logic stop_lamp_sw;
    logic clutch_sw;
    logic neutral_sw;
    logic park_sw;
    logic reverse_sw;
    logic traction_control;
    logic coolant_hot;
    logic diag_fault;
  } pins_t;

  typedef struct packed {
    logic [SPEED_W-1:0] vehicle_speed;
    logic [SPEED_W-1:0] powertrain_rev;
  } net_msg_t;
endpackage : cruise_pkg

// File: rtl/pin_sync.sv
// three-stage synchroniser with agreement filter for driver pins
module pin_sync #(
  parameter int WIDTH = 13
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [WIDTH-1:0] pin_in, // raw asynchronous pins
  output logic [WIDTH-1:0] pin_out // filtered level
);
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic q_reg;
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        q_reg <= 1'b0;
      end else begin
        s1_reg <= pin_in[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        // a change counts only once stages two and three agree
        if (s2_reg == s3_reg) begin
          q_reg <= s3_reg;
        end
      end
    end
    assign pin_out[i] = q_reg;
  end
endmodule : pin_sync

// File: verification/cruise_control_monitor.sv
// port-level checker for the cruise control block
module cruise_control_monitor
  import cruise_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [31:0] prdata, // apb read data
  input wire logic main_lamp, // main-on lamp
  input wire logic engaged_lamp, // engaged lamp
  input wire logic [7:0] throttle_cmd, // throttle angle
  input wire logic throttle_active // throttle under command
);
  default clocking mon_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  property p_answer;
    setup_s |=> access_s;
  endproperty
  chk_ready_after_setup: assert property (p_answer)
    else $error("no ready in access cycle");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error answer");
  chk_idle_throttle: assert property (
    !throttle_active |-> throttle_cmd == THROTTLE_IDLE)
    else $error("throttle commanded while idle");
  chk_throttle_step: assert property (
    $changed(throttle_cmd) |-> throttle_cmd == 8'h00 ||
    throttle_cmd == $past(throttle_cmd) + THROTTLE_STEP ||
    throttle_cmd == $past(throttle_cmd) - THROTTLE_STEP)
    else $error("throttle jumped");
  chk_active_needs_main: assert property (
    throttle_active |-> main_lamp) else $error("throttle with main off");
  chk_active_lamp_on: assert property (
    throttle_active |-> engaged_lamp) else $error("engaged lamp off");
  // reset itself is checked here, so the default disable is overridden
  chk_reset_quiet: assert property (disable iff (1'b0) !rst_n |=>
    !main_lamp && !engaged_lamp && !pready && throttle_cmd == 8'h00)
    else $error("outputs active after reset");
endmodule : cruise_control_monitor

// File: verification/vehicle_net_model.sv
// network sender of vehicle speed and revolution words
module vehicle_net_model
  import cruise_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [7:0] speed_kmh, // speed to report
  output net_msg_t net_msg, // message word
  output logic net_valid // one-cycle strobe
);
  logic [2:0] tick_reg;
  // speed arrives only as messages, one every eight cycles
  always_ff @(posedge mclk) begin
    tick_reg <= rst_n ? tick_reg + 3'h1 : 3'h0;
    net_valid <= rst_n && tick_reg == 3'h7;
    // between strobes the word is scrambled so stale use shows up
    net_msg <= (tick_reg == 3'h7) ? {speed_kmh, 8'h20} : ~{speed_kmh, 8'h20};
  end
endmodule : vehicle_net_model

// File: verification/tb.sv
// self-checking bench for the cruise control block
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  miscompares++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb;
  import cruise_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, err, main_lamp, engaged_lamp, throttle_active;
  logic [7:0] throttle_cmd, speed_kmh = 8'h3c, keep;
  logic [12:0] pins = 0;
  net_msg_t net_msg;
  logic net_valid;
  int miscompares = 0, comparisons = 0, cycles = 0, tm, te;
  logic [23:0] rows [4] = '{24'h27_01_00, 24'h28_02_28, 24'h90_02_90,
    24'h91_01_00};
  logic [12:0] causes [7] = '{13'h0200, 13'h0100, 13'h0080, 13'h0020,
    13'h0010, 13'h0008, 13'h0004};
  always #25 mclk = ~mclk;
  cruise_control #(.RAMP_CYCLES(8), .SLOW_CYCLES(16), .FAST_CYCLES(4))
    cruise_control_inst (.mclk(mclk), .rst_n(rst_n), .pins(pins),
    .net_msg(net_msg), .net_valid(net_valid), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_lamp(main_lamp),
    .engaged_lamp(engaged_lamp), .throttle_cmd(throttle_cmd),
    .throttle_active(throttle_active));
  vehicle_net_model vehicle_net_model_inst (.mclk(mclk), .rst_n(rst_n),
    .speed_kmh(speed_kmh), .net_msg(net_msg), .net_valid(net_valid));
  task report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      report_and_stop;
    end
  end
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    // request held until ready is sampled high
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task hold(input logic [12:0] m, input int n);
    pins <= pins | m;
    repeat (n) @(posedge mclk);
    pins <= pins & ~m;
    repeat (8) @(posedge mclk);
  endtask : hold
  task wait_state(input logic [2:0] s);
    for (int i = 0; i < 40; i++) begin
      apb(0, OFF_STATUS, 0);
      if (rd[2:0] === s) break;
    end
    `CHK("state", s, rd[2:0])
  endtask : wait_state
  task blinks(input int n);
    logic m0, e0;
    tm = 0;
    te = 0;
    repeat (n) begin
      m0 = main_lamp;
      e0 = engaged_lamp;
      @(posedge mclk);
      tm += (m0 !== main_lamp);
      te += (e0 !== engaged_lamp);
    end
  endtask : blinks
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1;
    apb(0, OFF_CTRL, 0);
    `CHK("ctrl reset", 32'(CTRL_RESET), rd)
    apb(0, 32'h0000_0010, 0);
    `CHK("unmapped err", 1'b1, err)
    foreach (rows[i]) begin
      speed_kmh <= rows[i][23:16];
      pins <= 13'h1000;
      repeat (20) @(posedge mclk);
      hold(13'h0800, 8);
      wait_state(rows[i][10:8]);
      `CHK("engaged lamp", rows[i][9], engaged_lamp)
      `CHK("main lamp", 1'b1, main_lamp)
      apb(0, OFF_SET_SPEED, 0);
      `CHK("set speed", rows[i][7:0], rd[7:0])
      pins <= 0;
      wait_state(3'h0);
      apb(0, OFF_SET_SPEED, 0);
      `CHK("set erased", 8'h00, rd[7:0])
    end
    speed_kmh <= 8'h64;
    pins <= 13'h1000;
    repeat (20) @(posedge mclk);
    hold(13'h0800, 8);
    wait_state(3'h2);
    foreach (causes[i]) begin
      hold(causes[i], 8);
      wait_state(3'h5);
      apb(0, OFF_SET_SPEED, 0);
      `CHK("kept speed", 8'h64, rd[7:0])
      hold(13'h0400, 8);
      wait_state(3'h2);
    end
    pins <= pins | 13'h0100;
    wait_state(3'h5);
    hold(13'h0400, 8);
    wait_state(3'h5);
    // let the brake release settle before hold ors in the button
    pins <= 13'h1000;
    repeat (8) @(posedge mclk);
    hold(13'h0400, 8);
    wait_state(3'h2);
    speed_kmh <= 8'h58;
    repeat (40) @(posedge mclk);
    wait_state(3'h2);
    `CHK("throttle on", 1'b1, throttle_active)
    `CHK("throttle up", 1'b1, throttle_cmd > THROTTLE_IDLE)
    speed_kmh <= 8'h57;
    wait_state(3'h5);
    // new speed must reach the block before resume, or it drops again
    speed_kmh <= 8'h64;
    repeat (20) @(posedge mclk);
    hold(13'h0400, 8);
    hold(13'h0400, 60);
    wait_state(3'h2);
    apb(0, OFF_SET_SPEED, 0);
    `CHK("accel raised", 1'b1, rd[7:0] > 8'h64)
    keep = rd[7:0];
    hold(13'h0800, 60);
    wait_state(3'h2);
    apb(0, OFF_SET_SPEED, 0);
    `CHK("coast lowered", 1'b1, rd[7:0] < keep)
    pins <= pins | 13'h0001;
    wait_state(3'h5);
    blinks(40);
    `CHK("fast blink", 1'b1, te > 4)
    `CHK("no throttle", 8'h00, throttle_cmd)
    pins <= 13'h1002;
    wait_state(3'h5);
    blinks(80);
    `CHK("slow blink", 1'b1, tm > 2 && tm < 8)
    pins <= 13'h1000;
    repeat (20) @(posedge mclk);
    hold(13'h0400, 8);
    wait_state(3'h2);
    apb(1, OFF_CTRL, 32'h0000_0003);
    apb(0, OFF_CTRL, 0);
    `CHK("ctrl write", 32'h0000_0003, rd)
    hold(13'h0040, 8);
    wait_state(3'h5);
    hold(13'h0400, 8);
    wait_state(3'h2);
    hold(13'h0e00, 8);
    wait_state(3'h5);
    apb(0, OFF_SET_SPEED, 0);
    `CHK("cleared", 8'h00, rd[7:0])
    rst_n <= 0;
    repeat (4) @(posedge mclk);
    `CHK("reset main lamp", 1'b0, main_lamp)
    `CHK("reset throttle", 1'b0, throttle_active)
    rst_n <= 1;
    apb(0, OFF_CTRL, 0);
    `CHK("ctrl after reset", 32'(CTRL_RESET), rd)
    report_and_stop;
  end
endmodule : tb
bind cruise_control cruise_control_monitor cruise_control_monitor_inst (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .main_lamp(main_lamp),
  .engaged_lamp(engaged_lamp), .throttle_cmd(throttle_cmd),
  .throttle_active(throttle_active));
